// *** hw/fmh_host.sv ***
/*
  Host controller for a serial flash: dual and quad reads, continuous-read mode and page program.
  Assumes the flash samples on the rising serial clock and drives on the falling one (mode 0).
*/
// Behaviour
// - Dual I/O read sends the 24-bit address two bits per clock.
// - After the dual I/O opcode, address, dummy and data are two bits wide.
// - Quad output read: opcode, address on line zero, eight dummies, four-line data.
// - Host may end a quad read at any data point by raising select.
// - Host drives protect and hold lines high until quad output dummy phase.
// - Quad I/O read: serial opcode, four-line address, mode byte, four dummy cycles, four-line data.
// - After the quad I/O opcode, address, dummy and data are four bits wide.
// - Enhanced quad I/O sends a mode byte after address, then four dummies.
// - Page program is accepted only after a write-unlock command.
// - Page program keeps select low over opcode, address and at least one byte.
// - Program runs only when select rises on a byte boundary.
`timescale 1ns/1ps
module fmh_host #(
  parameter logic [7:0] DUAL_DUMMY = fmh_pkg::DUAL_DUMMY_DEF
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clk_en,
  input  wire fmh_pkg::fmh_cmd_type  cmd,
  input  wire logic                  cmd_valid,
  output logic                       cmd_ready,
  input  wire logic [7:0]            wr_data,
  input  wire logic                  wr_valid,
  output logic                       wr_ready,
  output logic [7:0]                 rd_data,
  output logic                       rd_valid,
  input  wire logic                  rd_ready,
  output logic                       done,
  output logic                       busy,
  output logic                       cont_mode,
  output logic [7:0]                 status_byte,
  output logic                       sclk,
  output logic                       cs_n,
  input  wire logic [3:0]            io_i,
  output fmh_pkg::fmh_pins_type      io
);
  import fmh_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_OPC, S_ADDR, S_MODE, S_DUMMY, S_RD, S_WR, S_END} fmh_state_type;
  typedef enum logic [2:0] {J_NONE, J_UNLOCK, J_MAIN, J_POLL, J_EXIT} fmh_job_type;

  fmh_state_type st_r, st_nxt;
  fmh_job_type   job_r, job_nxt;
  fmh_cmd_type   cur_r, cur_nxt;
  fmh_pins_type  pins_r, pins_nxt;
  logic [31:0]   sh_r, sh_nxt;
  logic [7:0]    rx_r, rx_nxt, rx_in, cnt_r, cnt_nxt, wbuf_r, wbuf_nxt, stat_r, stat_nxt;
  logic [8:0]    len_r, len_nxt;
  logic [2:0]    div_r, div_nxt, lanes_r, lanes_nxt;
  logic          sclk_r, sclk_nxt, cs_n_r, cs_n_nxt, cont_r, cont_nxt;
  logic          wfull_r, wfull_nxt, done_r, done_nxt;
  logic          tick, push, fifo_rdy, need_wr, keep_hi;
  logic [3:0]    io_s;

  function automatic logic [2:0] addr_lanes(input fmh_op_type op);
    case (op)
      OP_DUAL_IO: return 3'd2;
      OP_QUAD_IO: return 3'd4;
      default:    return 3'd1;
    endcase
  endfunction : addr_lanes

  function automatic logic [2:0] rd_lanes(input fmh_op_type op);
    case (op)
      OP_DUAL_IO:  return 3'd2;
      OP_QUAD_OUT: return 3'd4;
      OP_QUAD_IO:  return 3'd4;
      default:     return 3'd1;
    endcase
  endfunction : rd_lanes

  function automatic logic [7:0] op_code(input fmh_op_type op);
    case (op)
      OP_DUAL_IO:  return OPC_DUAL_IO;
      OP_QUAD_OUT: return OPC_QUAD_OUT;
      OP_QUAD_IO:  return OPC_QUAD_IO;
      OP_PAGE:     return OPC_PAGE;
      default:     return OPC_STATUS;
    endcase
  endfunction : op_code

  // ==========================================================================
  // Pin synchroniser and read buffer
  fmh_sync #(.W(SYNC_W)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .d       (io_i),
    .q       (io_s)
  );

  // A full buffer holds the serial clock low, so a slow reader never loses bytes.
  fmh_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .in_data   (rx_in),
    .in_valid  (push),
    .in_ready  (fifo_rdy),
    .out_data  (rd_data),
    .out_valid (rd_valid),
    .out_ready (rd_ready)
  );

  // ==========================================================================
  // User side
  assign cmd_ready   = clk_en && st_r == S_IDLE && cnt_r == 8'd0 && job_r == J_NONE &&
                       !(cont_r && cmd.op != OP_QUAD_IO);
  assign wr_ready    = clk_en && !wfull_r;
  assign done        = done_r;
  assign busy        = st_r != S_IDLE || job_r != J_NONE;
  assign cont_mode   = cont_r;
  assign status_byte = stat_r;
  assign sclk        = sclk_r;
  assign cs_n        = cs_n_r;
  assign io          = pins_r;
  assign tick        = div_r == SCK_HALF_CLKS - 3'd1;
  assign need_wr     = cnt_r == 8'd1 && ((st_r == S_ADDR && cur_r.op == OP_PAGE) || (st_r == S_WR && len_r != 9'd0));

  // ==========================================================================
  // Transfer engine
  always_comb begin
    st_nxt = st_r;
    job_nxt = job_r;
    cur_nxt = cur_r;
    sh_nxt = sh_r;
    rx_nxt = rx_r;
    cnt_nxt = cnt_r;
    len_nxt = len_r;
    div_nxt = div_r;
    lanes_nxt = lanes_r;
    sclk_nxt = sclk_r;
    cs_n_nxt = cs_n_r;
    cont_nxt = cont_r;
    wbuf_nxt = wbuf_r;
    wfull_nxt = wfull_r;
    stat_nxt = stat_r;
    done_nxt = 1'b0;
    push = 1'b0;
    case (lanes_r)
      3'd1:    rx_in = {rx_r[6:0], io_s[1]};
      3'd2:    rx_in = {rx_r[5:0], io_s[1:0]};
      default: rx_in = {rx_r[3:0], io_s};
    endcase
    if (wr_valid && !wfull_r) begin
      wbuf_nxt = wr_data;
      wfull_nxt = 1'b1;
    end
    case (st_r)
      S_IDLE: begin
        if (cnt_r != 8'd0) begin
          cnt_nxt = cnt_r - 8'd1;
        end else if (job_r != J_NONE) begin
          cs_n_nxt = 1'b0;
          div_nxt = 3'd0;
          len_nxt = (job_r == J_MAIN || job_r == J_EXIT) ? cur_r.len : 9'd0;
          if (cont_r && cur_r.op == OP_QUAD_IO && (job_r == J_MAIN || job_r == J_EXIT)) begin
            st_nxt = S_ADDR;
            lanes_nxt = 3'd4;
            cnt_nxt = ADDR_BITS >> 2;
            sh_nxt = {cur_r.addr, 8'h00};
          end else begin
            st_nxt = S_OPC;
            lanes_nxt = 3'd1;
            cnt_nxt = BYTE_BITS;
            sh_nxt = {(job_r == J_UNLOCK) ? OPC_UNLOCK : (job_r == J_POLL) ? OPC_STATUS : op_code(cur_r.op), 24'h00_0000};
          end
        end else if (cmd_valid && cont_r && cmd.op != OP_QUAD_IO) begin
          cur_nxt = fmh_cmd_type'{op: OP_QUAD_IO, addr: cmd.addr, mode: MODE_EXIT, len: 9'd0};
          job_nxt = J_EXIT;
        end else if (cmd_valid) begin
          cur_nxt = cmd;
          job_nxt = (cmd.op == OP_PAGE) ? J_UNLOCK : J_MAIN;
        end
      end
      S_END: begin
        if (!tick) begin
          div_nxt = div_r + 3'd1;
        end else begin
          st_nxt = S_IDLE;
          cs_n_nxt = 1'b1;
          cnt_nxt = CS_GAP_CLKS;
          if (cur_r.op == OP_QUAD_IO && (job_r == J_MAIN || job_r == J_EXIT)) begin
            cont_nxt = cur_r.mode[7:4] == ~cur_r.mode[3:0];
          end
          case (job_r)
            J_UNLOCK: job_nxt = J_MAIN;
            J_MAIN: begin
              job_nxt = (cur_r.op == OP_PAGE) ? J_POLL : J_NONE;
              done_nxt = cur_r.op != OP_PAGE;
            end
            J_POLL: begin
              job_nxt = stat_r[BUSY_BIT] ? J_POLL : J_NONE;
              done_nxt = !stat_r[BUSY_BIT];
            end
            default: job_nxt = J_NONE;
          endcase
        end
      end
      default: begin
        if (!tick) begin
          div_nxt = div_r + 3'd1;
        end else if (!sclk_r) begin
          if (!(st_r == S_RD && cnt_r == 8'd1 && job_r == J_MAIN && !fifo_rdy)) begin
            div_nxt = 3'd0;
            sclk_nxt = 1'b1;
            rx_nxt = rx_in;
            if (st_r == S_RD && cnt_r == 8'd1) begin
              push = job_r == J_MAIN;
              if (job_r == J_POLL || cur_r.op == OP_STATUS) begin
                stat_nxt = rx_in;
              end
            end
          end
        end else if (!need_wr || wfull_r) begin
          div_nxt = 3'd0;
          sclk_nxt = 1'b0;
          cnt_nxt = cnt_r - 8'd1;
          sh_nxt = sh_r << lanes_r;
          if (cnt_r == 8'd1) begin
            case (st_r)
              S_OPC: begin
                if (job_r == J_UNLOCK) begin
                  st_nxt = S_END;
                end else if (job_r == J_POLL || cur_r.op == OP_STATUS) begin
                  st_nxt = S_RD;
                  cnt_nxt = BYTE_BITS;
                end else begin
                  st_nxt = S_ADDR;
                  lanes_nxt = addr_lanes(cur_r.op);
                  cnt_nxt = ADDR_BITS >> (addr_lanes(cur_r.op) >> 1);
                  sh_nxt = {cur_r.addr, 8'h00};
                end
              end
              S_ADDR: begin
                case (cur_r.op)
                  OP_QUAD_IO: begin
                    st_nxt = S_MODE;
                    cnt_nxt = MODE_CLKS;
                    sh_nxt = {cur_r.mode, 24'h00_0000};
                  end
                  OP_PAGE: begin
                    st_nxt = S_WR;
                    cnt_nxt = BYTE_BITS;
                    sh_nxt = {wbuf_r, 24'h00_0000};
                    wfull_nxt = 1'b0;
                  end
                  OP_QUAD_OUT: begin
                    st_nxt = S_DUMMY;
                    lanes_nxt = 3'd4;
                    cnt_nxt = QOUT_DUMMY;
                  end
                  default: begin
                    st_nxt = S_DUMMY;
                    cnt_nxt = DUAL_DUMMY;
                  end
                endcase
              end
              S_MODE: begin
                st_nxt = S_DUMMY;
                cnt_nxt = QIO_DUMMY;
              end
              S_DUMMY: begin
                st_nxt = S_RD;
                lanes_nxt = rd_lanes(cur_r.op);
                cnt_nxt = BYTE_BITS >> (rd_lanes(cur_r.op) >> 1);
              end
              default: begin
                if (len_r == 9'd0) begin
                  st_nxt = S_END;
                end else begin
                  len_nxt = len_r - 9'd1;
                  cnt_nxt = BYTE_BITS >> (lanes_r >> 1);
                  if (st_r == S_WR) begin
                    sh_nxt = {wbuf_r, 24'h00_0000};
                    wfull_nxt = 1'b0;
                  end
                end
              end
            endcase
          end
        end
      end
    endcase
    // Protect and hold lines are driven high except while four lines are in use.
    keep_hi = lanes_nxt != 3'd4;
    pins_nxt = fmh_pins_type'{o: 4'hC, oe: 4'hC};
    case (st_nxt)
      S_OPC, S_WR, S_ADDR, S_MODE: begin
        case (lanes_nxt)
          3'd1:    pins_nxt = fmh_pins_type'{o: {3'b110, sh_nxt[31]}, oe: 4'hD};
          3'd2:    pins_nxt = fmh_pins_type'{o: {2'b11, sh_nxt[31:30]}, oe: 4'hF};
          default: pins_nxt = fmh_pins_type'{o: sh_nxt[31:28], oe: 4'hF};
        endcase
      end
      S_DUMMY, S_RD: begin
        pins_nxt.oe = keep_hi ? ((lanes_nxt == 3'd1) ? 4'hD : 4'hC) : 4'h0;
      end
      default: pins_nxt.oe = 4'hC;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= S_IDLE;
      job_r <= J_NONE;
      cur_r <= '0;
      sh_r <= '0;
      rx_r <= '0;
      cnt_r <= '0;
      len_r <= '0;
      div_r <= '0;
      lanes_r <= 3'd1;
      sclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      cont_r <= 1'b0;
      wbuf_r <= '0;
      wfull_r <= 1'b0;
      stat_r <= '0;
      done_r <= 1'b0;
      pins_r <= fmh_pins_type'{o: 4'hC, oe: 4'hC};
    end else if (clk_en) begin
      st_r <= st_nxt;
      job_r <= job_nxt;
      cur_r <= cur_nxt;
      sh_r <= sh_nxt;
      rx_r <= rx_nxt;
      cnt_r <= cnt_nxt;
      len_r <= len_nxt;
      div_r <= div_nxt;
      lanes_r <= lanes_nxt;
      sclk_r <= sclk_nxt;
      cs_n_r <= cs_n_nxt;
      cont_r <= cont_nxt;
      wbuf_r <= wbuf_nxt;
      wfull_r <= wfull_nxt;
      stat_r <= stat_nxt;
      done_r <= done_nxt;
      pins_r <= pins_nxt;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !clk_en);

  sequence s_qout_dummy;
    st_r == S_ADDR && cur_r.op == OP_QUAD_OUT ##1 st_r == S_DUMMY;
  endsequence
  sequence s_mode_dummy;
    st_r == S_MODE ##1 st_r == S_DUMMY;
  endsequence

  property p_dual_addr;
    $rose(st_r == S_ADDR) && cur_r.op == OP_DUAL_IO |-> cnt_r == 8'd12 && pins_r.oe == 4'hF;
  endproperty
  a_dual_addr: assert property (p_dual_addr) else $error("dual address phase length wrong");
  property p_dual_wide;
    st_r inside {S_ADDR, S_RD} && cur_r.op == OP_DUAL_IO && job_r == J_MAIN |-> lanes_r == 3'd2;
  endproperty
  a_dual_wide: assert property (p_dual_wide) else $error("dual phase not two lines");
  property p_qout_dummy;
    s_qout_dummy |-> cnt_r == 8'd8 && pins_r.oe == 4'h0;
  endproperty
  a_qout_dummy: assert property (p_qout_dummy) else $error("quad output dummy wrong");
  property p_wp_hold;
    st_r inside {S_OPC, S_ADDR} && lanes_r != 3'd4 |-> pins_r.oe[3:2] == 2'b11 && pins_r.o[3:2] == 2'b11;
  endproperty
  a_wp_hold: assert property (p_wp_hold) else $error("protect or hold not driven high");
  property p_qio_dummy;
    s_mode_dummy |-> cnt_r == 8'd4 && $past(cnt_r, 2) == 8'd1;
  endproperty
  a_qio_dummy: assert property (p_qio_dummy) else $error("quad I/O dummy wrong");
  property p_qio_wide;
    st_r inside {S_ADDR, S_MODE} && cur_r.op == OP_QUAD_IO |-> lanes_r == 3'd4 && pins_r.oe == 4'hF;
  endproperty
  a_qio_wide: assert property (p_qio_wide) else $error("quad I/O phase not four lines");
  property p_cont_skip;
    $fell(cs_n_r) && cont_r && cur_r.op == OP_QUAD_IO |-> st_r == S_ADDR;
  endproperty
  a_cont_skip: assert property (p_cont_skip) else $error("opcode sent in continuous mode");
  property p_cont_leave;
    $changed(cont_r) |-> cs_n_r && $past(st_r) == S_END;
  endproperty
  a_cont_leave: assert property (p_cont_leave) else $error("continuous mode changed mid frame");
  property p_page_unlock;
    $changed(job_r) && job_r == J_MAIN && cur_r.op == OP_PAGE |-> $past(job_r) == J_UNLOCK;
  endproperty
  a_page_unlock: assert property (p_page_unlock) else $error("page write without unlock");
  property p_byte_end;
    $rose(st_r == S_END) && cur_r.op == OP_PAGE && job_r == J_MAIN |-> $past(st_r) == S_WR && $past(cnt_r) == 8'd1;
  endproperty
  a_byte_end: assert property (p_byte_end) else $error("page write ends off a byte");
  property p_poll_done;
    done_r && cur_r.op == OP_PAGE |-> !stat_r[BUSY_BIT] && job_r == J_NONE;
  endproperty
  a_poll_done: assert property (p_poll_done) else $error("done while flash busy");
  property p_push_rise;
    push |=> sclk_r && st_r inside {S_RD, S_END};
  endproperty
  a_push_rise: assert property (p_push_rise) else $error("byte taken off a rising edge");
endmodule : fmh_host

// *** hw/fmh_pkg.sv ***
/*
  Shared constants and types for the multi-line serial flash host controller.
  Assumes a 100 MHz system clock and a flash clocked only by the serial clock that this host drives.
*/
package fmh_pkg;
  // ==========================================================================
  // Instruction codes
  localparam logic [7:0] OPC_DUAL_IO  = 8'hBB;
  localparam logic [7:0] OPC_QUAD_OUT = 8'h6B;
  localparam logic [7:0] OPC_QUAD_IO  = 8'hEB;
  localparam logic [7:0] OPC_PAGE     = 8'h02;
  localparam logic [7:0] OPC_UNLOCK   = 8'h06;
  localparam logic [7:0] OPC_STATUS   = 8'h05;
  localparam logic [7:0] MODE_EXIT    = 8'hFF;
  // ==========================================================================
  // Timing
  localparam int         CLK_MHZ       = 100;
  localparam int         SCK_HALF_NS   = 40;
  localparam logic [2:0] SCK_HALF_CLKS = 3'((SCK_HALF_NS * CLK_MHZ + 999) / 1000);
  localparam int         CS_HIGH_NS    = 50;
  localparam logic [7:0] CS_GAP_CLKS   = 8'((CS_HIGH_NS * CLK_MHZ + 999) / 1000);
  // ==========================================================================
  // Phase lengths in serial clocks
  localparam logic [7:0] ADDR_BITS      = 8'd24;
  localparam logic [7:0] BYTE_BITS      = 8'd8;
  localparam logic [7:0] MODE_CLKS      = 8'd2;
  localparam logic [7:0] QOUT_DUMMY     = 8'd8;
  localparam logic [7:0] QIO_DUMMY      = 8'd4;
  localparam logic [7:0] DUAL_DUMMY_DEF = 8'd4;
  // ==========================================================================
  // Status byte fields and buffering
  localparam int BUSY_BIT   = 0;
  localparam int WLATCH_BIT = 1;
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int SYNC_W     = 4;

  typedef enum logic [2:0] {OP_DUAL_IO, OP_QUAD_OUT, OP_QUAD_IO, OP_PAGE, OP_STATUS} fmh_op_type;

  typedef struct packed {
    fmh_op_type  op;
    logic [23:0] addr;
    logic [7:0]  mode;
    logic [8:0]  len;
  } fmh_cmd_type;

  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe;
  } fmh_pins_type;
endpackage : fmh_pkg

// *** hw/fmh_sync.sv ***
/*
  Two-flop synchroniser, one per bit.
  Assumes inputs are asynchronous to clk; the clock enable freezes both stages.
*/
`timescale 1ns/1ps
module fmh_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  // ==========================================================================
  // Per-bit stages
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_r;
      logic s2_r;
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
        end else if (clk_en) begin
          s1_r <= d[i];
          s2_r <= s1_r;
        end
      end
      assign q[i] = s2_r;
    end
  endgenerate
endmodule : fmh_sync

// *** hw/fmh_fifo.sv ***
/*
  Flip-flop FIFO with valid and ready on both sides.
  Assumes DEPTH is a power of two; the clock enable freezes it and blocks both handshakes.
*/
`timescale 1ns/1ps
module fmh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             wr, rd;

  // ==========================================================================
  // Pointers and fill level
  assign in_ready  = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data  = mem_r[rp_r];
  assign wr        = in_valid && in_ready && clk_en;
  assign rd        = out_valid && out_ready && clk_en;

  always_comb begin
    wp_nxt  = wr ? AW'(wp_r + 1'b1) : wp_r;
    rp_nxt  = rd ? AW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = (AW+1)'(cnt_r + (AW+1)'(wr) - (AW+1)'(rd));
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (clk_en) begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================================
  // Storage
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_ent
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          mem_r[i] <= '0;
        end else if (wr && wp_r == AW'(i)) begin
          mem_r[i] <= in_data;
        end
      end
    end
  endgenerate
endmodule : fmh_fifo

// *** test/fmh_flash_model.sv ***
/*
  Behavioural serial flash: dual, quad and continuous reads, write unlock, status and page write.
  Assumes mode 0 clocking and a bench that pulls released data lines high.
*/
`timescale 1ns/1ps
module fmh_flash_model #(
  parameter int          DUMMY2    = 4,
  parameter int          PROG_NS   = 3000,
  parameter logic [23:0] PROT_BASE = 24'hF0_0000
) (
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic [3:0] io_w,
  output logic      [3:0] f_q,
  output logic      [3:0] f_oe
);
  logic [7:0]  mem [int];
  logic [7:0]  pbuf [int];
  logic [7:0]  op, m;
  logic [23:0] a;
  logic        busy_flag = 1'b0, write_latch_flag = 1'b0, cont = 1'b0;
  int          bits, n;
  // ==========================================================================
  // Frame handling
  task automatic get(input int w, input int nb, output logic [23:0] v);
    v = '0;
    repeat (nb / w) begin
      @(posedge sclk);
      bits += w;
      v = (v << w) | 24'(io_w & 4'((1 << w) - 1));
    end
  endtask : get
  task automatic put(input int w, input logic [7:0] b);
    repeat (8 / w) begin
      @(negedge sclk);
      f_oe = 4'((1 << w) - 1) << (w == 1);
      f_q  = 4'(b >> (8 - w)) << (w == 1);
      b    = b << w;
    end
  endtask : put
  task automatic stream(input int w);
    forever begin
      put(w, mem.exists(int'(a)) ? mem[int'(a)] : a[7:0] ^ a[15:8]);
      a = a + 24'h00_0001;
    end
  endtask : stream
  task automatic serve();
    logic [23:0] v;
    if (cont) op = 8'hEB;
    else begin
      get(1, 8, v);
      op = v[7:0];
    end
    bits = 0;
    case (op)
      8'h05: forever put(1, {6'h00, write_latch_flag, busy_flag});
      8'hBB: begin
        get(2, 24, a);
        repeat (DUMMY2) @(posedge sclk);
        stream(2);
      end
      8'h6B: begin
        get(1, 24, a);
        repeat (8) @(posedge sclk);
        stream(4);
      end
      8'hEB: if (!busy_flag) begin
        get(4, 24, a);
        get(4, 8, v);
        m = v[7:0];
        repeat (4) @(posedge sclk);
        stream(4);
      end
      8'h02: if (write_latch_flag && !busy_flag) begin
        get(1, 24, a);
        bits = 0;
        forever begin
          get(1, 8, v);
          pbuf[int'(a[7:0] + 8'(n))] = v[7:0];
          n++;
        end
      end
      default: ;
    endcase
  endtask : serve
  initial begin
    f_oe = 4'h0;
    f_q  = 4'h0;
    forever begin
      @(negedge cs_n);
      op = 8'h00;
      n  = 0;
      pbuf.delete();
      fork
        serve();
        @(posedge cs_n);
      join_any
      disable fork;
      f_oe = 4'h0;
      if (op == 8'hEB && !busy_flag) cont = m[7:4] == ~m[3:0];
      if (op == 8'h06 && bits == 0) write_latch_flag = 1'b1;
      if (op == 8'h02 && n > 0 && bits == 8 * n && a < PROT_BASE) begin
        foreach (pbuf[k]) mem[int'({a[23:8], 8'(k)})] = pbuf[k];
        busy_flag = 1'b1;
      end
    end
  end
  // The latch is dropped before busy ends, so a poll never sees busy fall while it is still set.
  always @(posedge busy_flag) begin
    #(PROG_NS);
    write_latch_flag = 1'b0;
    busy_flag = 1'b0;
  end
endmodule : fmh_flash_model

// *** test/testbench.sv ***
/*
  Self-checking bench for the flash host: reads, continuous mode and page writes.
  Assumes the flash model; released data lines are pulled high here.
*/
`timescale 1ns/1ps
module testbench;
  import fmh_pkg::*;
  logic         clk = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0, wr_valid = 1'b0, rd_ready = 1'b0;
  fmh_cmd_type  cmd = '0;
  logic [7:0]   wr_data = 8'h00;
  logic [7:0]   rd_data, status_byte;
  logic         cmd_ready, wr_ready, rd_valid, done, busy, cont_mode, sclk, cs_n;
  logic [3:0]   io_w, f_q, f_oe;
  fmh_pins_type io;
  logic [7:0]   q [$];
  logic [7:0]   wq [$];
  logic [7:0]   wmem [int];
  int           miscompares = 0;
  int           n_compared = 0;
  // ==========================================================================
  // Harness
  always #5 clk = ~clk;
  assign io_w = (io.oe & io.o) | (~io.oe & f_oe & f_q) | (~io.oe & ~f_oe);
  fmh_host u_fmh_host (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .cmd(cmd), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .done(done), .busy(busy), .cont_mode(cont_mode),
    .status_byte(status_byte), .sclk(sclk), .cs_n(cs_n), .io_i(io_w), .io(io));
  fmh_flash_model u_fmh_flash_model (.sclk(sclk), .cs_n(cs_n), .io_w(io_w), .f_q(f_q), .f_oe(f_oe));
  function automatic logic [7:0] ev(input logic [23:0] a);
    return wmem.exists(int'(a)) ? wmem[int'(a)] : a[7:0] ^ a[15:8];
  endfunction : ev
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk
  task automatic results();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  // Reads stall the FIFO for 1500 cycles so longer bursts fill it and hold the serial clock.
  task automatic run(input fmh_op_type op, input logic [23:0] a, input logic [7:0] m, input logic [8:0] n);
    int k;
    int wi;
    bit dn;
    wi = 0;
    dn = 1'b0;
    q.delete();
    cmd <= '{op: op, addr: a, mode: m, len: n};
    cmd_valid <= 1'b1;
    for (k = 0; k < 40000 && !(dn && !rd_valid); k++) begin
      @(posedge clk);
      if (cmd_valid && cmd_ready) cmd_valid <= 1'b0;
      if (wr_valid && wr_ready) wi++;
      if (rd_valid && rd_ready) q.push_back(rd_data);
      if (done) dn = 1'b1;
      wr_valid <= wi < wq.size();
      wr_data <= wi < wq.size() ? wq[wi] : 8'h00;
      rd_ready <= k >= 1500;
    end
    if (k >= 40000) begin
      miscompares++;
      results();
    end
    wq.delete();
    if (op <= OP_QUAD_IO) begin
      chk(8'(q.size()), 8'(n) + 8'h01);
      foreach (q[i]) chk(q[i], ev(a + 24'(i)));
    end
  endtask : run
  // ==========================================================================
  // Scenarios
  task automatic t_quad_io();
    logic [7:0] md [5];
    md = '{8'hA5, 8'h0F, 8'h55, 8'h00, 8'hF0};
    for (int i = 0; i < 5; i++) begin
      run(OP_QUAD_IO, 24'h00_3300 + 24'(i * 9), md[i], 9'h002);
      chk({7'h00, cont_mode}, {7'h00, i < 2 || i == 4});
    end
  endtask : t_quad_io
  task automatic t_reads();
    run(OP_DUAL_IO, 24'hFF_FFF8, 8'h00, 9'h013);
    chk({7'h00, cont_mode}, 8'h00);
    run(OP_QUAD_OUT, 24'h01_2345, 8'h00, 9'h003);
  endtask : t_reads
  task automatic t_page();
    wq = '{8'h11, 8'h22, 8'h33};
    run(OP_PAGE, 24'h10_00FE, 8'h00, 9'h002);
    chk(status_byte, 8'h00);
    wmem[int'(24'h10_00FE)] = 8'h11;
    wmem[int'(24'h10_00FF)] = 8'h22;
    wmem[int'(24'h10_0000)] = 8'h33;
    run(OP_DUAL_IO, 24'h10_00FE, 8'h00, 9'h003);
    run(OP_QUAD_OUT, 24'h10_0000, 8'h00, 9'h001);
    for (int j = 0; j < 258; j++) begin
      wq.push_back(8'(j + 3 * (j >> 8)));
      wmem[int'({16'h2000, 8'(8'h10 + j)})] = 8'(j + 3 * (j >> 8));
    end
    run(OP_PAGE, 24'h20_0010, 8'h00, 9'h101);
    run(OP_DUAL_IO, 24'h20_000E, 8'h00, 9'h004);
    wq = '{8'hAB};
    run(OP_PAGE, 24'hF0_0010, 8'h00, 9'h000);
    run(OP_DUAL_IO, 24'hF0_0010, 8'h00, 9'h000);
  endtask : t_page
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_quad_io();
    t_reads();
    t_page();
    results();
  end
endmodule : testbench
